// ==== hw/lmtc_top.sv ====
// Purpose: Per-link mode, line code, rate and termination settings behind the host port
// Assumes: Host pins are asynchronous and are sampled through two flops
// Notes:   Settings outputs lag a register write by one edge
// Contract
// R1 - Four links each keep own settings, written over serial or parallel port
// R2 - Mode comes from family bit, Japan bit and format field
// R3 - T1: format 00 SF, 01 ESF, 10 DM, 11 SLC
// R4 - J1: format 00 SF, 01 ESF
// R5 - DM and SLC never appear in J1 operation
// R6 - Family bit clear gives E1, other mode fields ignored
// R7 - Framing may be bypassed in T1 or J1 and in E1
// R8 - T1 or J1 uses B8ZS or AMI, E1 uses HDB3 or AMI
// R9 - Violation insertion allowed only with AMI selected
// R10 - T1 or J1 system stream may run at 1.544 or 2.048 rate
// R11 - Four links may be multiplexed onto one of two 8.192 buses
// R12 - Termination top bit clear enables internal matching
// R13 - Low bits pick 75, 120, 100 or 110 ohm
// R14 - Termination top bit set disables internal matching
// R15 - J1 with format 10 or 11 falls back to J1 SF
`timescale 1ns/1ps
`default_nettype none
`include "lmtc_cfg.svh"

module lmtc_top (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Host port pins
  input  wire logic                   spien,
  input  wire logic                   mpm,
  input  wire logic                   cs_n,
  input  wire logic [9:0]             addr,
  input  wire logic                   pin_wr_sdi,
  input  wire logic                   pin_rd_sclk,
  input  wire logic [7:0]             d_in,
  output logic [7:0]                  d_out,
  output logic [7:0]                  d_oe,
  // Per-link settings
  output var lmtc_pkg::lmtc_frame_t   framing_mode [`LMTC_LINKS],
  output var lmtc_pkg::lmtc_code_t    line_code [`LMTC_LINKS],
  output logic [`LMTC_LINKS-1:0]      bpv_insert_en,
  output logic [`LMTC_LINKS-1:0]      rate_2048,
  output logic [`LMTC_LINKS-1:0]      unframed,
  output logic [`LMTC_LINKS-1:0]      int_match_en,
  output var lmtc_pkg::lmtc_imp_t     rx_impedance [`LMTC_LINKS],
  // Backplane multiplexing
  output logic                        mux_enable,
  output logic                        mux_bus_sel
);
  import lmtc_pkg::*;

  // Register state
  logic [7:0]  mode_reg [`LMTC_LINKS];
  logic [2:0]  term_reg [`LMTC_LINKS];
  logic [1:0]  mux_reg;

  // Offset match inside one link page
  function automatic logic reg_hit(input logic [9:0] a, input logic [1:0] link,
                                   input logic [7:0] ofs);
    return (a[9:8] == link) && (a[7:0] == ofs);
  endfunction

  // Read mux; unmapped offsets read as zero
  function automatic logic [7:0] rd_value(input logic [9:0] a);
    logic [7:0] v;
    v = `LMTC_UNMAPPED;
    if (a[7:0] == `LMTC_MODE_OFS) begin
      v = mode_reg[a[9:8]];
    end else if (a[7:0] == `LMTC_STAT_OFS) begin
      v = {1'h0, framing_mode[a[9:8]]};
    end else if (a[7:0] == `LMTC_TERM_OFS) begin
      v = {5'h00, term_reg[a[9:8]]};
    end else if (reg_hit(a, `LMTC_MUX_LINK, `LMTC_MUX_OFS)) begin
      v = {6'h00, mux_reg};
    end
    return v;
  endfunction

  // Two-flop pin sampling; only the second stage is read
  logic [22:0] pin_raw;
  logic [22:0] pin_s1;
  logic [22:0] pin_s2;
  assign pin_raw = {spien, mpm, cs_n, pin_wr_sdi, pin_rd_sclk, addr, d_in};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= `LMTC_PIN_IDLE;
      pin_s2 <= `LMTC_PIN_IDLE;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // Named views of the sampled pins
  wire       s_spien = pin_s2[22];
  wire       s_mpm   = pin_s2[21];
  wire       s_cs_n  = pin_s2[20];
  wire       s_wr    = pin_s2[19];
  wire       s_rd    = pin_s2[18];
  wire [9:0] s_addr  = pin_s2[17:8];
  wire [7:0] s_data  = pin_s2[7:0];

  // Parallel strobes: split read and write strobes, or a data strobe with direction
  wire par_sel = !s_spien && !s_cs_n;
  wire par_rd  = par_sel && (s_mpm ? !s_rd : (!s_rd && s_wr));
  wire par_wr  = par_sel && (s_mpm ? !s_wr : (!s_rd && !s_wr));
  logic       par_wr_q;
  logic [9:0] lat_addr;
  logic [7:0] lat_data;

  // Latch during the strobe, commit at its trailing edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      par_wr_q <= 1'b0;
      lat_addr <= 10'h000;
      lat_data <= 8'h00;
    end else begin
      par_wr_q <= par_wr;
      if (par_wr) begin
        lat_addr <= s_addr;
        lat_data <= s_data;
      end
    end
  end
  wire par_commit = par_wr_q && !par_wr;

  // Serial port: clock on the RD pin, data in on the WR pin
  logic        sclk_q;
  logic [4:0]  spi_cnt;
  logic [15:0] spi_in;
  logic [15:0] spi_hdr;
  logic [7:0]  spi_out;
  logic        sdo_bit;
  wire spi_sel   = s_spien && !s_cs_n;
  wire sclk_rise = spi_sel && s_rd && !sclk_q;
  wire sclk_fall = spi_sel && !s_rd && sclk_q;
  wire spi_rd_ph = spi_sel && (spi_cnt >= `LMTC_SPI_HDR_LEN) && spi_hdr[`LMTC_SPI_RD_BIT];
  wire [15:0] next_spi_in = {spi_in[14:0], s_wr};

  // Shift in on rising edges, shift out on falling edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q  <= 1'b0;
      spi_cnt <= 5'h00;
      spi_in  <= 16'h0000;
      spi_hdr <= 16'h0000;
      spi_out <= 8'h00;
      sdo_bit <= 1'b0;
    end else begin
      sclk_q <= s_rd;
      if (!spi_sel) begin
        spi_cnt <= 5'h00;
      end else begin
        if (sclk_rise && spi_cnt != `LMTC_SPI_LEN) begin
          spi_cnt <= spi_cnt + 5'h01;
          spi_in  <= next_spi_in;
          if (spi_cnt == `LMTC_SPI_HDR_LAST) begin
            spi_hdr <= next_spi_in;
            spi_out <= rd_value(next_spi_in[9:0]);
          end
        end
        if (sclk_fall && spi_rd_ph) begin
          sdo_bit <= spi_out[7];
          spi_out <= {spi_out[6:0], 1'b0};
        end
      end
    end
  end
  wire spi_commit = sclk_rise && (spi_cnt == `LMTC_SPI_LAST) && !spi_hdr[`LMTC_SPI_RD_BIT];

  // One write path for both ports; SPIEN picks the source
  wire       wr_en   = par_commit || spi_commit; // R1
  wire [9:0] wr_addr = s_spien ? spi_hdr[9:0] : lat_addr;
  wire [7:0] wr_data = s_spien ? next_spi_in[7:0] : lat_data;

  // Per-link settings registers and decoded outputs
  lmtc_frame_t next_frame [`LMTC_LINKS];
  lmtc_code_t  next_code  [`LMTC_LINKS];
  lmtc_imp_t   next_imp   [`LMTC_LINKS];
  logic [`LMTC_LINKS-1:0] next_bpv;
  logic [`LMTC_LINKS-1:0] next_rate;
  logic [`LMTC_LINKS-1:0] next_unfr;
  logic [`LMTC_LINKS-1:0] next_int;

  genvar l;
  generate
    for (l = 0; l < `LMTC_LINKS; l++) begin : g_link
      // Each link page is written only by its own address
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          mode_reg[l] <= `LMTC_MODE_RST;
          term_reg[l] <= `LMTC_TERM_RST;
        end else if (wr_en && reg_hit(wr_addr, 2'(l), `LMTC_MODE_OFS)) begin
          mode_reg[l] <= wr_data; // R1 R2
        end else if (wr_en && reg_hit(wr_addr, 2'(l), `LMTC_TERM_OFS)) begin
          term_reg[l] <= wr_data[2:0]; // R1
        end
      end

      lmtc_link_decode u_decode (
        .mode_val  (mode_reg[l]),
        .term_val  (term_reg[l]),
        .frame     (next_frame[l]),
        .code      (next_code[l]),
        .bpv_ok    (next_bpv[l]),
        .rate_2048 (next_rate[l]),
        .unframed  (next_unfr[l]),
        .int_match (next_int[l]),
        .imp       (next_imp[l])
      );

      // Outputs straight from flops, one cycle behind the register
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          framing_mode[l]  <= LMTC_FR_E1;
          line_code[l]     <= LMTC_LC_HDB3;
          bpv_insert_en[l] <= 1'b0;
          rate_2048[l]     <= 1'b0;
          unframed[l]      <= 1'b0;
          int_match_en[l]  <= 1'b1;
          rx_impedance[l]  <= LMTC_IM_75;
        end else begin
          framing_mode[l]  <= next_frame[l];
          line_code[l]     <= next_code[l];
          bpv_insert_en[l] <= next_bpv[l];
          rate_2048[l]     <= next_rate[l];
          unframed[l]      <= next_unfr[l];
          int_match_en[l]  <= next_int[l];
          rx_impedance[l]  <= next_imp[l];
        end
      end
    end
  endgenerate

  // Group multiplexing is global, so one register serves all links
  wire mux_hit = wr_en && reg_hit(wr_addr, `LMTC_MUX_LINK, `LMTC_MUX_OFS);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mux_reg     <= `LMTC_MUX_RST;
      mux_enable  <= 1'b0;
      mux_bus_sel <= 1'b0;
    end else begin
      if (mux_hit) begin
        mux_reg <= wr_data[1:0]; // R11
      end
      mux_enable  <= mux_reg[`LMTC_MUX_EN_BIT]; // R11
      mux_bus_sel <= mux_reg[`LMTC_MUX_BUS_BIT];
    end
  end

  // Data pins: full byte in parallel read, D0 alone carries SDO in serial mode
  wire [7:0] next_d_out = s_spien ? {7'h00, sdo_bit} : rd_value(s_addr);
  wire [7:0] next_d_oe  = s_spien ? {7'h00, spi_rd_ph} : {8{par_rd}};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      d_out <= 8'h00;
      d_oe  <= 8'h00;
    end else begin
      d_out <= next_d_out;
      d_oe  <= next_d_oe;
    end
  end

  // Checks on link 0; all links share the same logic
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence mode0_wr_s;
    wr_en && reg_hit(wr_addr, 2'h0, `LMTC_MODE_OFS);
  endsequence
  sequence mux_wr_s;
    mux_hit;
  endsequence

  mode_write_a: assert property (mode0_wr_s |=> mode_reg[0] == $past(wr_data)) // R1
    else $error("mode write not stored");
  other_link_a: assert property (mode0_wr_s |=> $stable(mode_reg[1])) // R1
    else $error("mode write leaked to another link");
  e1_mode_a: assert property (!mode_reg[0][`LMTC_FAM_BIT] |=> framing_mode[0] == LMTC_FR_E1) // R6
    else $error("family clear did not give E1");
  t1_format_a: assert property (mode_reg[0][3:0] == 4'h9 |=> framing_mode[0] == LMTC_FR_DIGITAL_MUX_FORMAT) // R2 R3
    else $error("T1 digital mux decode wrong");
  j1_format_a: assert property (mode_reg[0][3:0] == 4'h7 |=> framing_mode[0] == LMTC_FR_J1_ESF) // R4
    else $error("J1 ESF decode wrong");
  j1_reserved_a: assert property (mode_reg[0][3:0] == 4'hB |=> framing_mode[0] == LMTC_FR_J1_SF) // R5 R15
    else $error("J1 reserved code not SF");
  line_code_a: assert property (!mode_reg[0][`LMTC_AMI_BIT] && mode_reg[0][`LMTC_FAM_BIT]
                                |=> line_code[0] == LMTC_LC_B8ZS) // R8
    else $error("T1 line code not B8ZS");
  bpv_gate_a: assert property (bpv_insert_en[0] |-> $past(mode_reg[0][`LMTC_AMI_BIT])) // R9
    else $error("violation insertion without AMI");
  rate_t1_a: assert property (rate_2048[0] |-> $past(mode_reg[0][`LMTC_FAM_BIT])) // R10
    else $error("rate change outside T1 or J1");
  unframed_a: assert property (mode0_wr_s ##1 mode_reg[0][`LMTC_UNFR_BIT] |=> unframed[0]) // R7
    else $error("framing bypass not applied");
  mux_apply_a: assert property (mux_wr_s |-> ##2 mux_enable == $past(wr_data[0], 2)) // R11
    else $error("mux enable not applied");
  term_int_a: assert property (term_reg[0] == 3'h2 |=> int_match_en[0]
                               && rx_impedance[0] == LMTC_IM_100) // R12 R13
    else $error("internal 100 ohm not selected");
  term_ext_a: assert property (term_reg[0][2] |=> !int_match_en[0]
                               && rx_impedance[0] == LMTC_IM_EXT) // R14
    else $error("external termination not selected");

endmodule
`default_nettype wire

// ==== hw/lmtc_cfg.svh ====
// Purpose: Offsets, field positions, reset values and counts for the link mode block
// Assumes: Ten-bit host address; bits 9:8 pick the link, bits 7:0 the offset
// Notes:   Included by both design files
`ifndef LMTC_CFG_SVH
`define LMTC_CFG_SVH

// Link count and host addressing
`define LMTC_LINKS        4
`define LMTC_MODE_OFS     8'h20
`define LMTC_STAT_OFS     8'h21
`define LMTC_TERM_OFS     8'h32
`define LMTC_MUX_OFS      8'h4F
`define LMTC_MUX_LINK     2'h0
`define LMTC_UNMAPPED     8'h00

// Mode register fields
`define LMTC_FAM_BIT      0
`define LMTC_JPN_BIT      1
`define LMTC_FMT_LO       2
`define LMTC_FMT_HI       3
`define LMTC_UNFR_BIT     4
`define LMTC_AMI_BIT      5
`define LMTC_RATE_BIT     6
`define LMTC_BPV_BIT      7

// Frame format codes
`define LMTC_FMT_SF       2'h0
`define LMTC_FMT_ESF      2'h1
`define LMTC_FMT_DM       2'h2
`define LMTC_FMT_SLC      2'h3

// Termination field
`define LMTC_TERM_EXT_BIT 2
`define LMTC_TERM_75      2'h0
`define LMTC_TERM_120     2'h1
`define LMTC_TERM_100     2'h2
`define LMTC_TERM_110     2'h3

// Mux register fields
`define LMTC_MUX_EN_BIT   0
`define LMTC_MUX_BUS_BIT  1

// Reset values
`define LMTC_MODE_RST     8'h00
`define LMTC_TERM_RST     3'h0
`define LMTC_MUX_RST      2'h0
`define LMTC_PIN_IDLE     23'h1C0000

// Serial host frame: 16 header bits then 8 data bits
`define LMTC_SPI_HDR_LAST 5'h0F
`define LMTC_SPI_HDR_LEN  5'h10
`define LMTC_SPI_LAST     5'h17
`define LMTC_SPI_LEN      5'h18
`define LMTC_SPI_RD_BIT   15

`endif

// ==== hw/lmtc_pkg.sv ====
// Purpose: Types shared by the link mode and termination block
// Assumes: One-hot codes so each output bit can steer a datapath directly
// Notes:   Numbers live in lmtc_cfg.svh
package lmtc_pkg;

  // Framing selected for a link
  typedef enum logic [6:0] {
    LMTC_FR_T1_SF  = 7'h01,
    LMTC_FR_T1_ESF = 7'h02,
    LMTC_FR_DIGITAL_MUX_FORMAT  = 7'h04,
    LMTC_FR_T1_SLC = 7'h08,
    LMTC_FR_J1_SF  = 7'h10,
    LMTC_FR_J1_ESF = 7'h20,
    LMTC_FR_E1     = 7'h40
  } lmtc_frame_t;

  // Line code for both directions
  typedef enum logic [2:0] {
    LMTC_LC_AMI  = 3'h1,
    LMTC_LC_B8ZS = 3'h2,
    LMTC_LC_HDB3 = 3'h4
  } lmtc_code_t;

  // Receive termination
  typedef enum logic [4:0] {
    LMTC_IM_EXT  = 5'h01,
    LMTC_IM_75   = 5'h02,
    LMTC_IM_120  = 5'h04,
    LMTC_IM_100  = 5'h08,
    LMTC_IM_110  = 5'h10
  } lmtc_imp_t;

endpackage

// ==== hw/lmtc_link_decode.sv ====
// Purpose: Pure decode of one link's mode and termination settings
// Assumes: Caller registers every output
// Notes:   J1 with a DM or SLC code falls back to J1 super frame
`timescale 1ns/1ps
`default_nettype none
`include "lmtc_cfg.svh"

module lmtc_link_decode (
  // Stored settings
  input  wire logic [7:0]           mode_val,
  input  wire logic [2:0]           term_val,
  // Decoded settings
  output var lmtc_pkg::lmtc_frame_t frame,
  output var lmtc_pkg::lmtc_code_t  code,
  output logic                      bpv_ok,
  output logic                      rate_2048,
  output logic                      unframed,
  output logic                      int_match,
  output var lmtc_pkg::lmtc_imp_t   imp
);
  import lmtc_pkg::*;

  wire       family = mode_val[`LMTC_FAM_BIT];
  wire       japan  = mode_val[`LMTC_JPN_BIT];
  wire [1:0] fmt    = mode_val[`LMTC_FMT_HI:`LMTC_FMT_LO];
  wire       ami    = mode_val[`LMTC_AMI_BIT];
  wire       ext    = term_val[`LMTC_TERM_EXT_BIT];
  lmtc_frame_t t1_frame;
  lmtc_frame_t j1_frame;
  lmtc_imp_t   int_imp;

  // T1 table, all four codes legal
  assign t1_frame = (fmt == `LMTC_FMT_SF)  ? LMTC_FR_T1_SF  :
                    (fmt == `LMTC_FMT_ESF) ? LMTC_FR_T1_ESF :
                    (fmt == `LMTC_FMT_DM)  ? LMTC_FR_DIGITAL_MUX_FORMAT  : LMTC_FR_T1_SLC; // R3
  // J1 only has SF and ESF; reserved codes land on SF
  assign j1_frame = (fmt == `LMTC_FMT_ESF) ? LMTC_FR_J1_ESF : LMTC_FR_J1_SF; // R4 R5 R15
  // Family clear means E1, other fields do not matter
  assign frame = !family ? LMTC_FR_E1 : (japan ? j1_frame : t1_frame); // R2 R6

  // Line code family follows the carrier family
  assign code = ami ? LMTC_LC_AMI : (family ? LMTC_LC_B8ZS : LMTC_LC_HDB3); // R8
  // Violations only make sense on an AMI line
  assign bpv_ok    = mode_val[`LMTC_BPV_BIT] & ami; // R9
  // Rate conversion exists on the T1 or J1 side only
  assign rate_2048 = family & mode_val[`LMTC_RATE_BIT]; // R10
  assign unframed  = mode_val[`LMTC_UNFR_BIT]; // R7

  // Termination value
  assign int_imp = (term_val[1:0] == `LMTC_TERM_75)  ? LMTC_IM_75  :
                   (term_val[1:0] == `LMTC_TERM_120) ? LMTC_IM_120 :
                   (term_val[1:0] == `LMTC_TERM_100) ? LMTC_IM_100 : LMTC_IM_110; // R13
  assign int_match = !ext; // R12
  assign imp       = ext ? LMTC_IM_EXT : int_imp; // R14

endmodule
`default_nettype wire

// ==== verif/lmtc_top_bench.sv ====
// Purpose: Self-checking bench for the link mode and termination block
// Assumes: Host pins change on rising clk_sys edges; results are checked in order
// Notes:   Settings are snapped well after the 4 to 5 edge settle of a write
`timescale 1ns/1ps
`default_nettype none
`include "lmtc_cfg.svh"

module lmtc_top_bench;
  import lmtc_pkg::*;

  typedef struct packed {
    logic        snap;
    logic [1:0]  link;
    logic [20:0] val;
  } lmtc_note_t;

  // Design pins, all idle at time zero
  logic          clk_sys     = 1'b0;
  logic          rst_n       = 1'b0;
  logic          spien       = 1'b0;
  logic          mpm         = 1'b1;
  logic          cs_n        = 1'b1;
  logic [9:0]    addr        = 10'h000;
  logic          pin_wr_sdi  = 1'b1;
  logic          pin_rd_sclk = 1'b1;
  logic [7:0]    d_in        = 8'h00;
  logic [7:0]    d_out;
  logic [7:0]    d_oe;
  lmtc_frame_t   framing_mode [`LMTC_LINKS];
  lmtc_code_t    line_code [`LMTC_LINKS];
  logic [3:0]    bpv_insert_en;
  logic [3:0]    rate_2048;
  logic [3:0]    unframed;
  logic [3:0]    int_match_en;
  lmtc_imp_t     rx_impedance [`LMTC_LINKS];
  logic          mux_enable;
  logic          mux_bus_sel;

  // Bench state and reference model
  lmtc_note_t    exp_q [$];
  lmtc_note_t    nt;
  logic          snap_req = 1'b0;
  logic [7:0]    oe_q     = 8'h00;
  logic          sclk_b   = 1'b1;
  logic [7:0]    sdo_sh   = 8'h00;
  logic [7:0]    mode_m [4];
  logic [2:0]    term_m [4];
  logic [1:0]    mux_m;
  logic [7:0]    m;
  logic [20:0]   v;
  int            errors     = 0;
  int            n_compared = 0;

  always #2.5 clk_sys = ~clk_sys;

  lmtc_top u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .spien(spien), .mpm(mpm), .cs_n(cs_n),
    .addr(addr), .pin_wr_sdi(pin_wr_sdi), .pin_rd_sclk(pin_rd_sclk), .d_in(d_in),
    .d_out(d_out), .d_oe(d_oe), .framing_mode(framing_mode), .line_code(line_code),
    .bpv_insert_en(bpv_insert_en), .rate_2048(rate_2048), .unframed(unframed),
    .int_match_en(int_match_en), .rx_impedance(rx_impedance),
    .mux_enable(mux_enable), .mux_bus_sel(mux_bus_sel)
  );

  // Expected settings vector of one link
  function automatic logic [20:0] exp_vec(input logic [7:0] md, input logic [2:0] t);
    logic [6:0] fr;
    logic [2:0] lc;
    logic [4:0] im;
    fr = !md[0] ? 7'h40 : md[1] ? (md[3:2] == 2'h1 ? 7'h20 : 7'h10) : 7'h01 << md[3:2];
    lc = md[5] ? 3'h1 : (md[0] ? 3'h2 : 3'h4);
    im = t[2] ? 5'h01 : 5'h02 << t[1:0];
    return {mux_m, fr, lc, md[7] & md[5], md[6] & md[0], md[4], !t[2], im};
  endfunction

  function automatic logic [20:0] out_vec(input logic [1:0] l);
    return {mux_enable, mux_bus_sel, framing_mode[l], line_code[l], bpv_insert_en[l],
            rate_2048[l], unframed[l], int_match_en[l], rx_impedance[l]};
  endfunction

  task automatic check(input logic [20:0] seen, input logic [20:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Mirror of the writable registers; other offsets leave it alone
  task automatic upd(input logic [9:0] a, input logic [7:0] d);
    if (a[7:0] == `LMTC_MODE_OFS) mode_m[a[9:8]] = d;
    else if (a[7:0] == `LMTC_TERM_OFS) term_m[a[9:8]] = d[2:0];
    else if (a[7:0] == `LMTC_MUX_OFS && a[9:8] == `LMTC_MUX_LINK) mux_m = {d[0], d[1]};
  endtask

  // One parallel access; strobe held 6 cycles so the synced strobe is seen
  task automatic host_cyc(input logic rd, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cs_n        <= 1'b0;
    addr        <= a;
    d_in        <= d;
    pin_wr_sdi  <= rd;
    pin_rd_sclk <= mpm & ~rd;
    repeat (6) @(posedge clk_sys);
    cs_n        <= 1'b1;
    pin_wr_sdi  <= 1'b1;
    pin_rd_sclk <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    host_cyc(1'b0, a, d);
    upd(a, d);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] want);
    exp_q.push_back({1'b0, 2'h0, 13'h0000, want});
    host_cyc(1'b1, a, 8'($urandom()));
  endtask

  task automatic snap(input logic [1:0] l);
    exp_q.push_back({1'b1, l, exp_vec(mode_m[l], term_m[l])});
    @(posedge clk_sys);
    snap_req <= 1'b1;
    @(posedge clk_sys);
    snap_req <= 1'b0;
  endtask

  // Serial frame; SCLK high 4 cycles and low 8, idle low inside frames
  task automatic ser_cyc(input logic rd, input logic [9:0] a, input logic [7:0] d);
    logic [23:0] fr;
    fr = {rd, 5'h00, a, d};
    @(posedge clk_sys);
    spien       <= 1'b1;
    pin_rd_sclk <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cs_n        <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (4) @(posedge clk_sys);
      pin_wr_sdi  <= fr[i];
      repeat (4) @(posedge clk_sys);
      pin_rd_sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      pin_rd_sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    cs_n        <= 1'b1;
    repeat (4) @(posedge clk_sys);
    spien       <= 1'b0;
    pin_rd_sclk <= 1'b1;
    pin_wr_sdi  <= 1'b1;
    repeat (6) @(posedge clk_sys);
    if (!rd) upd(a, d);
  endtask

  task automatic ser_rd(input logic [9:0] a, input logic [7:0] want);
    exp_q.push_back({1'b0, 2'h0, 13'h0000, want});
    ser_cyc(1'b1, a, 8'($urandom()));
  endtask

  // Serial read is over once the D0 enable drops again
  wire ser_end = (d_oe === 8'h00) && (oe_q === 8'h01);

  // Result watcher: a rising full read enable, the end of a serial read
  // or a snap request takes the oldest note
  always @(posedge clk_sys) begin
    oe_q   <= d_oe;
    sclk_b <= pin_rd_sclk;
    // SDO bit stands on D0 when the bench raises SCLK
    if (spien && pin_rd_sclk && !sclk_b) sdo_sh <= {sdo_sh[6:0], d_out[0]};
    if (rst_n && (snap_req || (d_oe === 8'hFF && oe_q !== 8'hFF) || ser_end)) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("mismatch at %0t: seen %h expected %h", $time, d_out, 8'h00);
      end else begin
        nt = exp_q.pop_front();
        check(nt.snap ? out_vec(nt.link) : {13'h0000, ser_end ? sdo_sh : d_out}, nt.val);
      end
    end
  end

  task automatic test_done();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog far beyond the few thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'hBD578B31));
    for (int l = 0; l < 4; l++) begin
      mode_m[l] = `LMTC_MODE_RST;
      term_m[l] = `LMTC_TERM_RST;
    end
    mux_m = `LMTC_MUX_RST;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int l = 0; l < 4; l++) begin
      snap(2'(l));
      rd({2'(l), `LMTC_MODE_OFS}, 8'h00);
    end
    rd({`LMTC_MUX_LINK, `LMTC_MUX_OFS}, 8'h00);
    $display("test reset done");
    // Every family, variant and format code, both strobe styles
    for (int k = 0; k < 16; k++) begin
      m   = {4'($urandom()), 4'(k)};
      mpm <= k[2];
      wr({2'(k), `LMTC_MODE_OFS}, m);
      snap(2'(k));
      v = exp_vec(m, term_m[k[1:0]]);
      rd({2'(k), `LMTC_STAT_OFS}, {1'b0, v[18:12]});
      rd({2'(k), `LMTC_MODE_OFS}, m);
      wr({2'h0, `LMTC_MODE_OFS}, m);
      snap(2'h0);
    end
    $display("test mode decode done");
    for (int k = 0; k < 8; k++) begin
      wr({2'(k + 2), `LMTC_TERM_OFS}, {5'($urandom()), 3'(k)});
      snap(2'(k + 2));
    end
    $display("test termination done");
    // Links keep their own settings
    for (int l = 0; l < 4; l++) wr({2'(l), `LMTC_MODE_OFS}, 8'($urandom()));
    for (int l = 0; l < 4; l++) snap(2'(l));
    $display("test independence done");
    // Ignored writes: unmapped, read-only status, mux on another page
    wr({2'h1, `LMTC_UNMAPPED}, 8'hFF);
    wr({2'h1, `LMTC_STAT_OFS}, 8'hFF);
    wr({2'h1, `LMTC_MUX_OFS}, 8'h03);
    snap(2'h1);
    rd({2'h1, `LMTC_UNMAPPED}, 8'h00);
    $display("test refused done");
    for (int k = 0; k < 4; k++) begin
      wr({`LMTC_MUX_LINK, `LMTC_MUX_OFS}, 8'(k));
      snap(2'h3);
      rd({`LMTC_MUX_LINK, `LMTC_MUX_OFS}, 8'(k));
    end
    $display("test mux done");
    // Serial host port reaches the same registers
    ser_cyc(1'b0, {2'h2, `LMTC_MODE_OFS}, 8'h25);
    snap(2'h2);
    ser_rd({2'h2, `LMTC_MODE_OFS}, mode_m[2]);
    ser_cyc(1'b0, {2'h3, `LMTC_TERM_OFS}, 8'h06);
    snap(2'h3);
    ser_rd({2'h3, `LMTC_TERM_OFS}, {5'h00, term_m[3]});
    $display("test serial done");
    repeat (4) @(posedge clk_sys);
    check(21'(exp_q.size()), 21'h00000);
    test_done();
  end

endmodule
`default_nettype wire
